// ---- pbd_pkg.sv ----
`default_nettype none
package pbd_pkg;
    localparam int HOST_ADDR_W = 20;
    localparam int HOST_DATA_W = 8;
    localparam int PROC_DATA_W = 16;
    localparam int PROC_ADDR_W = 24;
    localparam int IO_DECODE_W = 10;
    localparam int CTL_PINS = 6;
    localparam int BUS_PINS = HOST_ADDR_W + HOST_DATA_W;

    localparam logic [9:0] IO_RANGE_BASE = 10'h160;
    localparam logic [9:0] REG_WINDOW_BASE_OFFSET = 10'h165;
    localparam logic [9:0] REG_STATUS_READ_KEYS_WRITE = 10'h166;

    localparam int PORT_SIM_PF = 1;
    localparam int PORT_NVRAM_GATE = 2;
    localparam int PORT_MASTER_CLEAR = 3;
    localparam int PORT_OFFSET = 5;
    localparam int PORT_STATUS_KEYS = 6;
    localparam int PORT_RELEASE = 7;

    localparam int ADDR_MEM_SPACE_BIT = 19;
    localparam int ADDR_WINDOW_SEL_BIT = 18;
    localparam int ADDR_EXTRA_HALF_BIT = 16;

    localparam logic [7:0] OFFSET_RESET = 8'h00;
    localparam logic [7:0] KEYS_RESET = 8'hff;
    localparam logic [3:0] POWER_FAIL_INT_CODE = 4'ha;
    localparam logic [5:0] CTL_SYNC_RESET = 6'h0f;
    localparam logic [27:0] BUS_SYNC_RESET = 28'h000_0000;

    typedef enum logic [1:0] {
        MEM_IDLE = 2'h0,
        MEM_REQ = 2'h1,
        MEM_HOLD = 2'h3
    } pbd_mem_state_type;
endpackage
`default_nettype wire

// ---- pbd_pin_sync.sv ----
`default_nettype none
module pbd_pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] stable_out
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    wire [WIDTH-1:0] agree = ~(stage2 ^ stage3);

    // A bit only moves once two later stages agree, so a single-cycle glitch is filtered.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            meta <= RST_VAL;
            stage2 <= RST_VAL;
            stage3 <= RST_VAL;
            stable_out <= RST_VAL;
        end else begin
            meta <= pin_in;
            stage2 <= meta;
            stage3 <= stage2;
            stable_out <= (agree & stage3) | (~agree & stable_out);
        end
    end
endmodule
`default_nettype wire

// ---- pbd_io_decode.sv ----
`default_nettype none
module pbd_io_decode
    import pbd_pkg::*;
(
    input wire logic [IO_DECODE_W-1:0] addr_low,
    input wire logic dma_addr_enable,
    input wire logic io_read,
    input wire logic io_write,
    output logic io_decode_enable,
    output logic [7:0] port_sel
);
    wire in_range = addr_low[IO_DECODE_W-1:3] == IO_RANGE_BASE[IO_DECODE_W-1:3];

    // DMA cycles carry a DMA address on the bus and must never hit these ports.
    assign io_decode_enable = in_range && !dma_addr_enable && (io_read || io_write);
    assign port_sel = io_decode_enable ? 8'h01 << addr_low[2:0] : 8'h00;
endmodule
`default_nettype wire

// ---- pbd_io_port_decoder.sv ----
// Behaviour
// - Host bus: 20-bit address, 8-bit data, IO/mem strobes
// - Bytes split and merged onto 16-bit words
// - Host may write the lower half of processor memory via offset
// - Memory window is 64 kbyte at offset
// - Decode ports 160-167 with strobes and AEN
// - IO enable selects one of eight ports
// - Write 161 pulses simulated power fail
// - Write 162 pulses NV-RAM write gate
// - Write 163 pulses master clear
// - Access 167 pulses processor release
// - Control strobes ignore host data
// - Port 166 reads status, writes keys
// - Power fail from simulated fail or reset
// - Offset port write loads offset register
// - Offset port read returns offset register
// - Granted memory access latches extra offset
// - Power fail raises internal code 12 octal
// - Keys load on write, status on read
// - Address bit 18 picks window or extra
`default_nettype none
module pbd_io_port_decoder
    import pbd_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [HOST_ADDR_W-1:0] host_addr,
    input wire logic [HOST_DATA_W-1:0] host_data_in,
    output logic [HOST_DATA_W-1:0] host_data_out,
    output logic host_data_oe,
    input wire logic host_io_read_n,
    input wire logic host_io_write_n,
    input wire logic host_mem_read_n,
    input wire logic host_mem_write_n,
    input wire logic host_dma_addr_enable,
    input wire logic host_bus_reset,
    input wire logic [7:0] status_bits,
    input wire logic [7:0] extra_mem_base,
    input wire logic proc_mem_grant,
    input wire logic [PROC_DATA_W-1:0] proc_rd_data,
    output logic sim_power_fail_strobe,
    output logic nvram_write_gate_strobe,
    output logic host_master_clear_strobe,
    output logic processor_release_strobe,
    output logic host_power_fail,
    output logic power_fail_internal_int,
    output logic [3:0] power_fail_int_code,
    output logic [7:0] keys_value,
    output logic [7:0] window_base_offset,
    output logic extra_mem_addr_latch,
    output logic extra_mem_half,
    output logic proc_mem_req,
    output logic proc_mem_we,
    output logic [PROC_ADDR_W-1:0] proc_word_addr,
    output logic [PROC_DATA_W-1:0] proc_wr_data,
    output logic [1:0] proc_byte_en
);
    logic [CTL_PINS-1:0] ctl_s;
    logic [BUS_PINS-1:0] bus_s;

    pbd_pin_sync #(.WIDTH(CTL_PINS), .RST_VAL(CTL_SYNC_RESET)) u_ctl_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .pin_in({host_bus_reset, host_dma_addr_enable, host_mem_write_n,
                 host_mem_read_n, host_io_write_n, host_io_read_n}),
        .stable_out(ctl_s)
    );

    // Address and data take the same path as the strobes, so they stay aligned with them.
    pbd_pin_sync #(.WIDTH(BUS_PINS), .RST_VAL(BUS_SYNC_RESET)) u_bus_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .pin_in({host_data_in, host_addr}),
        .stable_out(bus_s)
    );

    wire io_rd = !ctl_s[0];
    wire io_wr = !ctl_s[1];
    wire mem_rd = !ctl_s[2];
    wire mem_wr = !ctl_s[3];
    wire dma_aen = ctl_s[4];
    wire bus_rst = ctl_s[5];
    wire [HOST_ADDR_W-1:0] addr_s = bus_s[HOST_ADDR_W-1:0];
    wire [HOST_DATA_W-1:0] data_s = bus_s[BUS_PINS-1:HOST_ADDR_W];

    logic io_rd_q;
    logic io_wr_q;
    logic mem_rd_q;
    logic mem_wr_q;
    logic io_hit;
    logic [7:0] io_sel_q;
    logic io_decode_enable;
    logic [7:0] port_sel;

    pbd_io_decode u_io_decode (
        .addr_low(addr_s[IO_DECODE_W-1:0]),
        .dma_addr_enable(dma_aen),
        .io_read(io_rd),
        .io_write(io_wr),
        .io_decode_enable(io_decode_enable),
        .port_sel(port_sel)
    );

    wire io_active = io_rd || io_wr;
    wire io_lead = io_active && !(io_rd_q || io_wr_q);
    wire io_end = !io_active && (io_rd_q || io_wr_q);
    wire io_start_hit = io_lead && io_decode_enable;
    // Writes act at the trailing edge, where the host data is sure to be valid.
    wire wr_done = io_hit && io_wr_q && !io_wr;

    // Control ports act on decode alone and never look at data_s.
    wire next_sim_pf = wr_done && io_sel_q[PORT_SIM_PF];
    wire next_nvram_gate = wr_done && io_sel_q[PORT_NVRAM_GATE];
    wire next_master_clear = wr_done && io_sel_q[PORT_MASTER_CLEAR];
    wire next_release = io_start_hit && port_sel[PORT_RELEASE];
    wire offset_load_strobe = wr_done && io_sel_q[PORT_OFFSET];
    wire keys_load_strobe = wr_done && io_sel_q[PORT_STATUS_KEYS];
    wire offset_read_enable = io_hit && io_rd && io_sel_q[PORT_OFFSET];
    wire status_read_enable = io_hit && io_rd && io_sel_q[PORT_STATUS_KEYS];
    wire next_power_fail = next_sim_pf || bus_rst;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            io_rd_q <= 1'b0;
            io_wr_q <= 1'b0;
            mem_rd_q <= 1'b0;
            mem_wr_q <= 1'b0;
            io_hit <= 1'b0;
            io_sel_q <= 8'h00;
        end else begin
            io_rd_q <= io_rd;
            io_wr_q <= io_wr;
            mem_rd_q <= mem_rd;
            mem_wr_q <= mem_wr;
            if (io_start_hit) begin
                io_hit <= 1'b1;
                io_sel_q <= port_sel;
            end else if (io_end) begin
                io_hit <= 1'b0;
                io_sel_q <= 8'h00;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sim_power_fail_strobe <= 1'b0;
            nvram_write_gate_strobe <= 1'b0;
            host_master_clear_strobe <= 1'b0;
            processor_release_strobe <= 1'b0;
            host_power_fail <= 1'b0;
            power_fail_internal_int <= 1'b0;
            power_fail_int_code <= 4'h0;
        end else begin
            sim_power_fail_strobe <= next_sim_pf;
            nvram_write_gate_strobe <= next_nvram_gate;
            host_master_clear_strobe <= next_master_clear;
            processor_release_strobe <= next_release;
            host_power_fail <= next_power_fail;
            power_fail_internal_int <= host_power_fail;
            power_fail_int_code <= host_power_fail ? POWER_FAIL_INT_CODE : 4'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            window_base_offset <= OFFSET_RESET;
            keys_value <= KEYS_RESET;
        end else begin
            if (offset_load_strobe) begin
                window_base_offset <= data_s;
            end
            if (keys_load_strobe) begin
                keys_value <= data_s;
            end
        end
    end

    pbd_mem_state_type mem_state;
    pbd_mem_state_type next_mem_state;
    logic [HOST_ADDR_W-1:0] mem_addr_q;
    logic [HOST_DATA_W-1:0] mem_rd_byte;

    wire mem_hit = addr_s[ADDR_MEM_SPACE_BIT] && !dma_aen;
    wire mem_rd_start = mem_hit && mem_rd && !mem_rd_q;
    wire mem_wr_start = mem_hit && mem_wr_q && !mem_wr;
    wire granted = mem_state == MEM_REQ && proc_mem_grant;
    // Bit 18 picks the movable window or the donated extra area for the upper lines.
    wire [8:0] upper_sel = addr_s[ADDR_WINDOW_SEL_BIT] ? {1'b0, window_base_offset}
                                                       : {extra_mem_base, addr_s[ADDR_EXTRA_HALF_BIT]};
    wire [PROC_ADDR_W-1:0] next_word_addr = {upper_sel, addr_s[15:1]};
    wire [1:0] next_byte_en = addr_s[0] ? 2'h2 : 2'h1;
    wire [HOST_DATA_W-1:0] lane_byte = mem_addr_q[0] ? proc_rd_data[15:8] : proc_rd_data[7:0];

    always_comb begin
        next_mem_state = mem_state;
        case (mem_state)
            MEM_IDLE: begin
                if (mem_rd_start || mem_wr_start) begin
                    next_mem_state = MEM_REQ;
                end
            end
            MEM_REQ: begin
                if (proc_mem_grant) begin
                    next_mem_state = proc_mem_we ? MEM_IDLE : MEM_HOLD;
                end
            end
            MEM_HOLD: begin
                if (!mem_rd) begin
                    next_mem_state = MEM_IDLE;
                end
            end
            default: begin
                next_mem_state = MEM_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mem_state <= MEM_IDLE;
            mem_addr_q <= 20'h0_0000;
            mem_rd_byte <= 8'h00;
            proc_mem_req <= 1'b0;
            proc_mem_we <= 1'b0;
            proc_word_addr <= 24'h00_0000;
            proc_wr_data <= 16'h0000;
            proc_byte_en <= 2'h0;
            extra_mem_addr_latch <= 1'b0;
            extra_mem_half <= 1'b0;
        end else begin
            mem_state <= next_mem_state;
            extra_mem_addr_latch <= granted;
            if (mem_state == MEM_IDLE && next_mem_state == MEM_REQ) begin
                mem_addr_q <= addr_s;
                proc_mem_req <= 1'b1;
                proc_mem_we <= mem_wr_start;
                proc_word_addr <= next_word_addr;
                proc_wr_data <= {data_s, data_s};
                proc_byte_en <= next_byte_en;
            end else if (granted) begin
                proc_mem_req <= 1'b0;
                mem_rd_byte <= lane_byte;
                extra_mem_half <= mem_addr_q[ADDR_EXTRA_HALF_BIT];
            end
        end
    end

    // Reserved and control ports never enable the bus driver.
    wire next_data_oe = offset_read_enable || status_read_enable || mem_state == MEM_HOLD;
    wire [7:0] next_data_out = offset_read_enable ? window_base_offset :
                               status_read_enable ? status_bits :
                               mem_state == MEM_HOLD ? mem_rd_byte : 8'h00;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            host_data_oe <= 1'b0;
            host_data_out <= 8'h00;
        end else begin
            host_data_oe <= next_data_oe;
            host_data_out <= next_data_out;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    property p_sim_pf_fail;
        (sim_power_fail_strobe || $past(bus_rst)) |-> host_power_fail;
    endproperty
    a_sim_pf_fail: assert property (p_sim_pf_fail) else $error("power fail missed simulated fail");

    property p_fail_code;
        host_power_fail |=> power_fail_internal_int && power_fail_int_code == POWER_FAIL_INT_CODE;
    endproperty
    a_fail_code: assert property (p_fail_code) else $error("power fail interrupt code wrong");

    property p_sim_pf_pulse;
        sim_power_fail_strobe |=> !sim_power_fail_strobe;
    endproperty
    a_sim_pf_pulse: assert property (p_sim_pf_pulse) else $error("strobe longer than one cycle");

    property p_one_strobe;
        $onehot0({sim_power_fail_strobe, nvram_write_gate_strobe, host_master_clear_strobe,
                  processor_release_strobe});
    endproperty
    a_one_strobe: assert property (p_one_strobe) else $error("two port strobes at once");

    property p_offset_load;
        offset_load_strobe |=> window_base_offset == $past(data_s);
    endproperty
    a_offset_load: assert property (p_offset_load) else $error("offset not loaded");

    property p_offset_read;
        offset_read_enable |=> host_data_oe && host_data_out == $past(window_base_offset);
    endproperty
    a_offset_read: assert property (p_offset_read) else $error("offset not returned");

    property p_keys_load;
        keys_load_strobe |=> keys_value == $past(data_s);
    endproperty
    a_keys_load: assert property (p_keys_load) else $error("keys not loaded");

    property p_drive_cause;
        host_data_oe |-> $past(io_hit && io_rd && (io_sel_q[PORT_OFFSET] || io_sel_q[PORT_STATUS_KEYS]))
                         || $past(mem_state == MEM_HOLD);
    endproperty
    a_drive_cause: assert property (p_drive_cause) else $error("data bus driven without cause");

    property p_extra_mem_addr_latch;
        proc_mem_req && proc_mem_grant |=> extra_mem_addr_latch ##1 !extra_mem_addr_latch;
    endproperty
    a_extra_mem_addr_latch: assert property (p_extra_mem_addr_latch) else $error("extra offset latch not pulsed");

    property p_byte_lane;
        proc_mem_req |-> $onehot(proc_byte_en);
    endproperty
    a_byte_lane: assert property (p_byte_lane) else $error("byte lane not one-hot");

    property p_release_pulse;
        processor_release_strobe |=> !processor_release_strobe;
    endproperty
    a_release_pulse: assert property (p_release_pulse) else $error("release strobe too long");

    property p_reset_fail;
        bus_rst |=> host_power_fail;
    endproperty
    a_reset_fail: assert property (p_reset_fail) else $error("bus reset did not raise power fail");

    // Reads of reserved and control ports must leave the bus alone.
    property p_quiet_read;
        io_hit && io_rd && !io_sel_q[PORT_OFFSET] && !io_sel_q[PORT_STATUS_KEYS] && mem_state != MEM_HOLD
            |=> !host_data_oe;
    endproperty
    a_quiet_read: assert property (p_quiet_read) else $error("bus driven on a silent port");

    property p_window_addr;
        mem_state == MEM_IDLE && next_mem_state == MEM_REQ && addr_s[ADDR_WINDOW_SEL_BIT]
            |=> proc_word_addr[PROC_ADDR_W-1 -: 9] == {1'b0, $past(window_base_offset)};
    endproperty
    a_window_addr: assert property (p_window_addr) else $error("window base not on upper lines");

    c_power_fail: cover property (sim_power_fail_strobe ##1 power_fail_internal_int);
    c_offset_load: cover property (offset_load_strobe);
    c_mem_read: cover property (mem_state == MEM_HOLD && host_data_oe);
    c_release: cover property (processor_release_strobe);
endmodule
`default_nettype wire

// ---- pbd_host_model.sv ----
`default_nettype none
module pbd_host_model
    import pbd_pkg::*;
(
    input wire logic clk,
    output logic [HOST_ADDR_W-1:0] host_addr,
    output logic [HOST_DATA_W-1:0] host_data_in,
    output logic host_io_read_n,
    output logic host_io_write_n,
    output logic host_mem_read_n,
    output logic host_mem_write_n,
    output logic host_dma_addr_enable,
    output logic host_bus_reset,
    input wire logic [HOST_DATA_W-1:0] host_data_out,
    input wire logic host_data_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] strobe_n;
    assign {host_mem_write_n, host_mem_read_n, host_io_write_n, host_io_read_n} = strobe_n;
    initial begin
        host_addr = 20'h0_0000;
        host_data_in = 8'h00;
        host_dma_addr_enable = 1'b0;
        host_bus_reset = 1'b0;
        strobe_n = 4'hf;
    end
    // One strobe at a time, low for hold cycles, then high for a long gap.
    task automatic cycle(input int kind, input logic [19:0] addr, input logic [7:0] data,
                         input logic dma, input int hold, output logic [7:0] rd, output logic seen_oe);
        logic [3:0] next_strobe_n;
        next_strobe_n = 4'hf;
        next_strobe_n[kind] = 1'b0;
        rd = 8'h00;
        seen_oe = 1'b0;
        host_addr <= addr;
        host_data_in <= kind[0] ? data : ~data;
        host_dma_addr_enable <= dma;
        strobe_n <= next_strobe_n;
        for (int i = 0; i < hold + 10; i++) begin
            @(posedge clk);
            if (host_data_oe === 1'b1) begin
                seen_oe = 1'b1;
                rd = host_data_out;
            end
            if (i == hold - 1) strobe_n <= 4'hf;
            // Released lines show the inverse, so a stale value can never pass for a fresh one.
            if (i == hold + 1) begin
                host_addr <= ~addr;
                host_data_in <= ~host_data_in;
                host_dma_addr_enable <= 1'b0;
            end
        end
    endtask
    task automatic bus_reset(input int n);
        host_bus_reset <= 1'b1;
        repeat (n) @(posedge clk);
        host_bus_reset <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ---- pbd_io_port_decoder_tb.sv ----
`default_nettype none
module pbd_io_port_decoder_tb
    import pbd_pkg::*;
    ;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, sys_rst, host_data_oe, host_io_read_n, host_io_write_n, host_mem_read_n, host_mem_write_n;
    logic host_dma_addr_enable, host_bus_reset, proc_mem_grant, proc_mem_req, proc_mem_we, oe;
    logic sim_power_fail_strobe, nvram_write_gate_strobe, host_master_clear_strobe, processor_release_strobe;
    logic host_power_fail, power_fail_internal_int, extra_mem_addr_latch, extra_mem_half, got_we, got_half;
    logic [HOST_ADDR_W-1:0] host_addr;
    logic [7:0] host_data_in, host_data_out, status_bits, extra_mem_base, keys_value, window_base_offset, rd;
    logic [3:0] power_fail_int_code;
    logic [PROC_ADDR_W-1:0] proc_word_addr, got_addr;
    logic [15:0] proc_rd_data, proc_wr_data, got_wd;
    logic [1:0] proc_byte_en, got_be;
    logic [6:0] ev;
    int cnt[7];
    int code_bad, wait_cnt, n_errors, comparisons;

    pbd_io_port_decoder dut (.clk, .sys_rst, .host_addr, .host_data_in, .host_data_out, .host_data_oe,
        .host_io_read_n, .host_io_write_n, .host_mem_read_n, .host_mem_write_n, .host_dma_addr_enable,
        .host_bus_reset, .status_bits, .extra_mem_base, .proc_mem_grant, .proc_rd_data, .sim_power_fail_strobe,
        .nvram_write_gate_strobe, .host_master_clear_strobe, .processor_release_strobe, .host_power_fail,
        .power_fail_internal_int, .power_fail_int_code, .keys_value, .window_base_offset, .extra_mem_addr_latch,
        .extra_mem_half, .proc_mem_req, .proc_mem_we, .proc_word_addr, .proc_wr_data, .proc_byte_en);
    pbd_host_model host (.clk, .host_addr, .host_data_in, .host_io_read_n, .host_io_write_n, .host_mem_read_n,
        .host_mem_write_n, .host_dma_addr_enable, .host_bus_reset, .host_data_out, .host_data_oe);

    initial clk = 1'b0;
    always #12.5 clk = ~clk;
    assign ev = {extra_mem_addr_latch, power_fail_internal_int, host_power_fail, processor_release_strobe,
                 host_master_clear_strobe, nvram_write_gate_strobe, sim_power_fail_strobe};
    // Count high cycles of every event output so one-cycle pulses cannot slip past between samples.
    always @(posedge clk) begin
        for (int i = 0; i < 7; i++) if (ev[i] === 1'b1) cnt[i]++;
        if (extra_mem_addr_latch === 1'b1) got_half = extra_mem_half;
        if (!sys_rst && power_fail_int_code !== (power_fail_internal_int ? 4'ha : 4'h0)) code_bad++;
    end
    // Slow memory side: grants a request four cycles late and records what was asked.
    always @(posedge clk) begin
        if (sys_rst) begin
            proc_mem_grant <= 1'b0;
            wait_cnt <= 0;
        end else if (proc_mem_req === 1'b1 && proc_mem_grant !== 1'b1) begin
            wait_cnt <= wait_cnt + 1;
            if (wait_cnt == 3) begin
                proc_mem_grant <= 1'b1;
                got_addr <= proc_word_addr;
                got_we <= proc_mem_we;
                got_be <= proc_byte_en;
                got_wd <= proc_wr_data;
            end
        end else begin
            proc_mem_grant <= 1'b0;
            wait_cnt <= 0;
        end
    end

    task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic results;
        if (n_errors == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic clear;
        foreach (cnt[i]) cnt[i] = 0;
        code_bad = 0;
    endtask
    task automatic io(input int kind, input logic [19:0] a, input logic [7:0] d, input logic dma);
        @(posedge clk);
        host.cycle(kind, a, d, dma, 10, rd, oe);
    endtask

    task automatic t_reset;
        check("keys", keys_value, KEYS_RESET);
        check("offset", window_base_offset, OFFSET_RESET);
        check("oe", host_data_oe, 1'b0);
    endtask
    task automatic t_ports;
        logic w;
        for (int p = 0; p < 8; p++) begin
            for (int k = 0; k < 2; k++) begin
                clear;
                io(k, 20'h0_0160 + 20'(p), 8'h5a, 1'b0);
                w = (k == 1);
                check("sim", 24'(cnt[0]), w && p == 1);
                check("nvram", 24'(cnt[1]), w && p == 2);
                check("mclear", 24'(cnt[2]), w && p == 3);
                check("release", 24'(cnt[3]), p == 7);
                check("pfail", 24'(cnt[4]), w && p == 1);
                check("pf_int", 24'(cnt[5]), w && p == 1);
                check("oe", oe, !w && (p == 5 || p == 6));
                if (!w && p == 5) check("offset_rd", rd, OFFSET_RESET);
                if (!w && p == 6) check("status_rd", rd, status_bits);
            end
        end
        check("offset", window_base_offset, 8'h5a);
        check("keys", keys_value, 8'h5a);
    endtask
    task automatic t_misc;
        clear;
        io(1, 20'h0_0162, 8'h00, 1'b0);
        check("nvram_d0", 24'(cnt[1]), 1);
        io(1, 20'h0_0161, 8'hff, 1'b1);
        io(1, 20'h0_0165, 8'h22, 1'b1);
        io(1, 20'h0_0365, 8'h11, 1'b0);
        io(0, 20'h0_0166, 8'h00, 1'b1);
        check("sim_dma", 24'(cnt[0]), 0);
        check("oe_dma", oe, 1'b0);
        check("offset_kept", window_base_offset, 8'h5a);
    endtask
    task automatic t_power;
        clear;
        @(posedge clk);
        host.bus_reset(10);
        repeat (12) @(posedge clk);
        check("pfail_rst", 24'(cnt[4]), 10);
        check("pf_int_rst", 24'(cnt[5]), 10);
        check("pf_code", 24'(code_bad), 0);
    endtask
    task automatic t_mem;
        io(1, 20'h0_0165, 8'h3a, 1'b0);
        clear;
        @(posedge clk);
        host.cycle(2, 20'hc_1235, 8'h00, 1'b0, 22, rd, oe);
        check("rd_addr", got_addr, {1'b0, 8'h3a, 15'h091a});
        check("rd_we", got_we, 1'b0);
        check("rd_be", got_be, 2'b10);
        check("rd_byte", rd, 8'hbe);
        check("rd_latch", 24'(cnt[6]), 1);
        check("rd_half", got_half, 1'b0);
        clear;
        @(posedge clk);
        host.cycle(3, 20'h9_4566, 8'h77, 1'b0, 6, rd, oe);
        repeat (10) @(posedge clk);
        check("wr_addr", got_addr, {8'hc3, 1'b1, 15'h22b3});
        check("wr_we", got_we, 1'b1);
        check("wr_be", got_be, 2'b01);
        check("wr_data", got_wd, 16'h7777);
        check("wr_latch", 24'(cnt[6]), 1);
        check("wr_half", got_half, 1'b1);
        check("wr_oe", oe, 1'b0);
    endtask

    initial begin
        sys_rst = 1'b1;
        status_bits = 8'h3c;
        extra_mem_base = 8'hc3;
        proc_rd_data = 16'hbeef;
        n_errors = 0;
        comparisons = 0;
        clear;
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        t_reset;
        t_ports;
        t_misc;
        t_power;
        t_mem;
        results;
    end
    // The whole run needs well under a thousand cycles; four thousand means a hang.
    initial begin
        #100_000;
        n_errors++;
        results;
    end
endmodule
`default_nettype wire
